//--- hdl/smc_master_ctrl.sv
`timescale 1ns/1ps
module smc_master_ctrl (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_serial_port_enable,
  input wire logic i_select_lines_enable,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_busy,
  output logic o_sclk,
  output logic o_sclk_oe_n,
  output logic o_mosi,
  output logic o_mosi_oe_n,
  input wire logic i_miso,
  input wire logic i_sclk,
  input wire logic i_ss_n,
  output logic o_miso,
  output logic o_miso_oe_n,
  output logic [3:0] o_select_n
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] ctrl_q, ctrl_d, cfg_q, cfg_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] div_code;
  logic [1:0] sel_code;
  logic phase, pol, master, slow, active;

  assign div_code = ctrl_q[smc_pkg::DIV_LSB +: 3];
  assign sel_code = ctrl_q[smc_pkg::SEL_LSB +: 2];
  assign phase = ctrl_q[smc_pkg::PHASE_BIT];
  assign pol = ctrl_q[smc_pkg::POL_BIT];
  assign master = ctrl_q[smc_pkg::MASTER_BIT];
  assign slow = cfg_q[smc_pkg::SLOW_BIT];
  assign active = i_serial_port_enable;

  // Register writes only while the port is enabled; a read while it is off returns zero
  always_comb begin
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    rdata_d = rdata_q;
    if (active && i_sfr_wr && i_sfr_addr == smc_pkg::CTRL_ADDR) begin
      ctrl_d = i_sfr_wdata;
    end
    if (active && i_sfr_wr && i_sfr_addr == smc_pkg::CONFIG_ADDR) begin
      cfg_d = {4'h0, i_sfr_wdata[smc_pkg::SLOW_BIT], 3'h0};
    end
    if (i_sfr_rd) begin
      if (!active) begin
        rdata_d = 8'h00;
      end else if (i_sfr_addr == smc_pkg::CTRL_ADDR) begin
        rdata_d = ctrl_q;
      end else if (i_sfr_addr == smc_pkg::CONFIG_ADDR) begin
        rdata_d = cfg_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= smc_pkg::CTRL_RESET;
      cfg_q <= smc_pkg::CONFIG_RESET;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end
  assign o_sfr_rdata = rdata_q;

  // ------------------------------------------------------------
  // Transmit buffer
  // ------------------------------------------------------------
  smc_stream_if #(.W(smc_pkg::DATA_W)) tx_in ();
  smc_stream_if #(.W(smc_pkg::DATA_W)) tx_out ();
  assign tx_in.valid = i_tx_valid && active;
  assign tx_in.data = i_tx_data;
  assign o_tx_ready = tx_in.ready && active;

  smc_fifo #(.WIDTH(smc_pkg::DATA_W), .DEPTH(smc_pkg::FIFO_DEPTH)) u_tx_fifo (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .s_in(tx_in),
    .s_out(tx_out)
  );

  // ------------------------------------------------------------
  // Pin synchronisers (slave role)
  // ------------------------------------------------------------
  logic [2:0] sync1_q, sync2_q, sync_last_q;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_q <= 3'b110;
      sync2_q <= 3'b110;
      sync_last_q <= 3'b110;
    end else begin
      sync1_q <= {i_ss_n, i_sclk, i_miso};
      sync2_q <= sync1_q;
      sync_last_q <= sync2_q;
    end
  end
  logic s_ss_n, s_sclk, s_miso, s_sclk_prev, s_rise, s_fall;
  assign s_miso = sync2_q[0];
  assign s_sclk = sync2_q[1];
  assign s_ss_n = sync2_q[2];
  assign s_sclk_prev = sync_last_q[1];
  assign s_rise = s_sclk && !s_sclk_prev;
  assign s_fall = !s_sclk && s_sclk_prev;

  // ------------------------------------------------------------
  // Master clock divider and shifter
  // ------------------------------------------------------------
  // Half period in core clocks: 2^code, times four in slow mode
  logic [9:0] half_len;
  always_comb begin
    half_len = 10'(10'h001 << div_code);
    if (slow) begin
      half_len = 10'(half_len * 10'(smc_pkg::SLOW_FACTOR));
    end
  end

  smc_pkg::smc_state_e st_q, st_d;
  logic [9:0] cnt_q, cnt_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, rx_q, rx_d;
  logic sck_q, sck_d, rxv_q, rxv_d, mosi_q, mosi_d;
  logic [1:0] sel_lat_q, sel_lat_d;
  logic lead_edge_out;

  // Phase 0 moves data on rising edges, phase 1 on falling edges;
  // polarity decides whether the first edge of a frame is the rising one
  assign lead_edge_out = (phase == pol);
  // The cycle after a frame keeps the select low, so no byte starts then
  assign tx_out.ready = master && active && (st_q == smc_pkg::SMC_IDLE) && !rxv_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rx_d = rx_q;
    sck_d = sck_q;
    rxv_d = 1'b0;
    mosi_d = mosi_q;
    sel_lat_d = sel_lat_q;
    case (st_q)
      smc_pkg::SMC_IDLE: begin
        sck_d = pol;
        cnt_d = 10'h001;
        bit_d = 3'h0;
        if (!master || !active) begin
          mosi_d = 1'b0;
        end else if (tx_out.valid && !rxv_q) begin
          // Output-on-first-edge modes put bit 7 out at that edge instead
          if (lead_edge_out) begin
            sh_d = tx_out.data;
          end else begin
            sh_d = {tx_out.data[6:0], 1'b0};
            mosi_d = tx_out.data[7];
          end
          sel_lat_d = sel_code;
          st_d = smc_pkg::SMC_LEAD;
        end
      end
      smc_pkg::SMC_LEAD: begin
        if (cnt_q >= half_len) begin
          cnt_d = 10'h001;
          sck_d = !sck_q;
          // Modes with phase unequal to polarity sample on this edge; equal phase and polarity shift on it
          if (!lead_edge_out) begin
            rx_d = {rx_q[6:0], i_miso};
          end else begin
            mosi_d = sh_q[7];
            sh_d = {sh_q[6:0], 1'b0};
          end
          st_d = smc_pkg::SMC_TRAIL;
        end else begin
          cnt_d = cnt_q + 10'h001;
        end
      end
      smc_pkg::SMC_TRAIL: begin
        if (cnt_q >= half_len) begin
          cnt_d = 10'h001;
          sck_d = !sck_q;
          if (lead_edge_out) begin
            rx_d = {rx_q[6:0], i_miso};
          end else if (bit_q != 3'h7) begin
            mosi_d = sh_q[7];
            sh_d = {sh_q[6:0], 1'b0};
          end
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            rxv_d = 1'b1;
            st_d = smc_pkg::SMC_IDLE;
          end else begin
            st_d = smc_pkg::SMC_LEAD;
          end
        end else begin
          cnt_d = cnt_q + 10'h001;
        end
      end
      default: st_d = smc_pkg::SMC_IDLE;
    endcase
    // Slave role: shift from the external master's clock
    if (!master && active && !s_ss_n) begin
      if (phase ? s_rise : s_fall) begin
        rx_d = {rx_q[6:0], s_miso};
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= smc_pkg::SMC_IDLE;
      cnt_q <= 10'h001;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      sck_q <= 1'b0;
      rxv_q <= 1'b0;
      mosi_q <= 1'b0;
      sel_lat_q <= 2'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      sck_q <= sck_d;
      rxv_q <= rxv_d;
      mosi_q <= mosi_d;
      sel_lat_q <= sel_lat_d;
    end
  end

  // ------------------------------------------------------------
  // Pins and select lines
  // ------------------------------------------------------------
  assign o_busy = (st_q != smc_pkg::SMC_IDLE);
  assign o_rx_valid = rxv_q;
  assign o_rx_data = rx_q;
  assign o_sclk = sck_q;
  assign o_mosi = mosi_q;
  assign o_sclk_oe_n = !(master && active);
  assign o_mosi_oe_n = !(master && active);
  assign o_miso = sh_q[7];
  assign o_miso_oe_n = !(!master && active && !s_ss_n);

  // One-hot low select during a master transfer; 1-3 need the enable
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sel
      logic chosen;
      // Held one cycle past the last edge so the slave sees it inside the frame
      assign chosen = (o_busy || rxv_q) && master && (sel_lat_q == 2'(g));
      if (g == 0) begin : g_zero
        assign o_select_n[g] = !chosen;
      end else begin : g_other
        assign o_select_n[g] = !(chosen && i_select_lines_enable);
      end
    end
  endgenerate
endmodule // smc_master_ctrl

//--- common/smc_pkg.sv
package smc_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'hc1;     // spi_master_control
  localparam logic [7:0] CONFIG_ADDR = 8'hc2;   // spi_configuration
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int DIV_LSB = 5;
  localparam int SEL_LSB = 3;
  localparam int PHASE_BIT = 2;
  localparam int POL_BIT = 1;
  localparam int MASTER_BIT = 0;
  localparam int SLOW_BIT = 3;
  localparam int SLOW_FACTOR = 4;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int BIT_CNT_W = 3;
  typedef enum logic [2:0] {
    SMC_IDLE = 3'b001,
    SMC_LEAD = 3'b010,
    SMC_TRAIL = 3'b100
  } smc_state_e;
endpackage

//--- common/smc_stream_if.sv
`timescale 1ns/1ps
interface smc_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- hdl/smc_fifo.sv
`timescale 1ns/1ps
module smc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  smc_stream_if.snk s_in,
  smc_stream_if.src s_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // ------------------------------------------------------------
  // Pointers and fill count
  // ------------------------------------------------------------
  // Full only when the count reaches the depth; an empty FIFO must accept
  assign s_in.ready = (cnt_q < (AW+1)'(DEPTH));
  assign s_out.valid = (cnt_q != '0);
  assign s_out.data = mem_q[rd_q];
  assign push = s_in.valid && s_in.ready;
  assign pop = s_out.valid && s_out.ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; empty flag guards stale words
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wr_q] <= s_in.data;
    end
  end
endmodule // smc_fifo

//--- verification/smc_slave_model.sv
`timescale 1ns/1ps
// ----------
// Far-side serial slave
// ----------
module smc_slave_model (
  input wire logic i_sclk,
  input wire logic i_sel_n,
  input wire logic i_mosi,
  input wire logic i_pol,
  input wire logic i_pha,
  input wire logic [7:0] i_reply,
  output logic o_miso,
  output logic [7:0] o_got
);
  logic [7:0] sh_q = 8'h00;
  initial o_miso = 1'b0;
  // When the first edge samples, the first bit must stand before it
  always @(negedge i_sel_n) begin
    sh_q = i_reply;
    if (i_pha != i_pol) {o_miso, sh_q} = {sh_q, 1'b0};
  end
  // A released line shows the inverse, so a stale bit cannot pass
  always @(posedge i_sel_n) o_miso = ~o_miso;
  // Phase 0 samples on falling edges, phase 1 on rising; the other edge shifts
  always @(i_sclk) if (!i_sel_n) begin
    if (i_sclk == i_pha) o_got = {o_got[6:0], i_mosi};
    else {o_miso, sh_q} = {sh_q, 1'b0};
  end
endmodule // smc_slave_model

//--- verification/smc_master_ctrl_assertions.sv
`timescale 1ns/1ps
module smc_master_ctrl_assertions (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_serial_port_enable,
  input wire logic i_select_lines_enable,
  input wire logic o_tx_ready,
  input wire logic o_busy,
  input wire logic o_sclk,
  input wire logic o_sclk_oe_n,
  input wire logic o_mosi_oe_n,
  input wire logic o_miso_oe_n,
  input wire logic [3:0] o_select_n
);
  logic [7:0] ctl_q;
  logic slow_q;
  logic seen_q;
  logic [10:0] cnt_q;
  wire wr = i_sfr_wr && i_serial_port_enable;
  wire [10:0] half = 11'h001 << ({1'b0, ctl_q[7:5]} + {2'b00, slow_q, 1'b0});
  // Shadow of the mode plus a half-period counter, reset by each clock toggle
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl_q <= 8'h01;
      slow_q <= 1'b0;
      seen_q <= 1'b0;
      cnt_q <= 11'h000;
    end else begin
      if (wr && i_sfr_addr == smc_pkg::CTRL_ADDR) ctl_q <= i_sfr_wdata;
      if (wr && i_sfr_addr == smc_pkg::CONFIG_ADDR) slow_q <= i_sfr_wdata[3];
      seen_q <= o_busy && (seen_q || $changed(o_sclk));
      cnt_q <= $changed(o_sclk) ? 11'h000 : cnt_q + 11'h001;
    end
  end
  // ----------
  // Checks
  // ----------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  property p_one_line; $onehot0(~o_select_n); endproperty
  a_one_line: assert property (p_one_line)
    else $error("more than one select line low");
  property p_sel_line;
    (o_busy && ctl_q[0] && (ctl_q[4:3] == 2'b00 || i_select_lines_enable))
      |-> o_select_n == ~(4'h1 << ctl_q[4:3]);
  endproperty
  a_sel_line: assert property (p_sel_line)
    else $error("wrong select line");
  property p_sel_gate;
    (ctl_q[4:3] != 2'b00 && !i_select_lines_enable) |-> o_select_n == 4'hf;
  endproperty
  a_sel_gate: assert property (p_sel_gate)
    else $error("select line driven without enable");
  // The first toggle of a transfer is skipped: its lead-in is not a half period
  property p_half; ($changed(o_sclk) && seen_q && o_busy) |-> cnt_q + 11'h001 == half; endproperty
  a_half: assert property (p_half)
    else $error("serial clock half period wrong");
  property p_idle_lvl;
    (!o_busy && !$past(o_busy) && $stable(ctl_q) && ctl_q[0] && i_serial_port_enable)
      |-> o_sclk == ctl_q[1];
  endproperty
  a_idle_lvl: assert property (p_idle_lvl)
    else $error("serial clock idle level wrong");
  property p_slave;
    (!ctl_q[0] && !$past(ctl_q[0])) |-> o_select_n == 4'hf && o_sclk_oe_n && o_mosi_oe_n;
  endproperty
  a_slave: assert property (p_slave)
    else $error("master pins driven in slave role");
  property p_off;
    (!i_serial_port_enable && !$past(i_serial_port_enable))
      |-> o_sclk_oe_n && o_mosi_oe_n && o_miso_oe_n && !o_tx_ready && o_select_n == 4'hf;
  endproperty
  a_off: assert property (p_off)
    else $error("disabled port active");
  property p_rd_off; (i_sfr_rd && !i_serial_port_enable) |=> o_sfr_rdata == 8'h00; endproperty
  a_rd_off: assert property (p_rd_off)
    else $error("disabled port read not zero");
  property p_rd_ctl;
    (i_sfr_rd && !i_sfr_wr && i_serial_port_enable && i_sfr_addr == smc_pkg::CTRL_ADDR)
      |=> o_sfr_rdata == $past(ctl_q);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl)
    else $error("control read back wrong");
  c_slow: cover property (o_busy && slow_q);
  c_mode3: cover property (o_busy && ctl_q[2:1] == 2'b11);
  c_slave: cover property (!ctl_q[0]);
endmodule // smc_master_ctrl_assertions

bind smc_master_ctrl smc_master_ctrl_assertions u_chk (.*);

//--- verification/spi_master_mode_control_tb_top.sv
`timescale 1ns/1ps
module spi_master_mode_control_tb_top;
  logic i_core_clk, i_rstn, i_sfr_wr, i_sfr_rd, i_serial_port_enable, i_select_lines_enable;
  logic i_tx_valid, o_tx_ready, o_rx_valid, o_busy, o_sclk, o_sclk_oe_n, o_mosi, o_mosi_oe_n;
  logic i_miso, i_sclk, i_ss_n, o_miso, o_miso_oe_n, rd_q;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, i_tx_data, o_rx_data, ctl, reply, got;
  logic [3:0] o_select_n;
  logic [7:0] exp_rd[$], exp_rx[$], exp_tx[$];
  int err_total, cmp_count;
  smc_master_ctrl u_dut (.*);
  smc_slave_model u_far (.i_sclk(o_sclk), .i_sel_n(&o_select_n), .i_mosi(o_mosi),
    .i_pol(ctl[1]), .i_pha(ctl[2]), .i_reply(reply), .o_miso(i_miso), .o_got(got));
  // 25 MHz core clock
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Register access; a read notes its expected value first
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= w;
    i_sfr_rd <= !w;
    if (!w) exp_rd.push_back(d);
    @(posedge i_core_clk);
    i_sfr_wr <= 1'b0;
    i_sfr_rd <= 1'b0;
    @(posedge i_core_clk);
  endtask
  // Valid stays up across a burst so the FIFO is pushed until it refuses
  task automatic send(input int n);
    logic [7:0] d;
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      exp_tx.push_back(d);
      exp_rx.push_back(reply);
      i_tx_data <= d;
      i_tx_valid <= 1'b1;
      do @(posedge i_core_clk); while (o_tx_ready !== 1'b1);
    end
    i_tx_valid <= 1'b0;
    for (int k = 0; k < 40000 && exp_rx.size() > 0; k++) @(posedge i_core_clk);
    chk8("bytes_left", 8'h00, 8'(exp_rx.size()));
  endtask
  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Results are settled by the falling edge
  always @(posedge i_core_clk) rd_q <= i_sfr_rd;
  always @(negedge i_core_clk) begin
    if (rd_q === 1'b1) chk8("sfr_rdata", exp_rd.pop_front(), o_sfr_rdata);
    if (o_rx_valid === 1'b1) begin
      chk8("rx_data", exp_rx.pop_front(), o_rx_data);
      chk8("far_rx", exp_tx.pop_front(), got);
    end
  end
  initial begin
    #(40 * 60000);
    err_total++;
    wrap_up();
  end
  initial begin
    {i_rstn, i_sfr_wr, i_sfr_rd, i_serial_port_enable, i_select_lines_enable} = 5'h00;
    {i_tx_valid, i_sclk, i_ss_n} = 3'h1;
    {i_sfr_addr, i_sfr_wdata, i_tx_data, ctl, reply} = 40'h0;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(46));
    repeat (4) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    @(posedge i_core_clk);
    sfr(1'b0, smc_pkg::CTRL_ADDR, 8'h00);
    i_serial_port_enable <= 1'b1;
    i_select_lines_enable <= 1'b1;
    sfr(1'b0, smc_pkg::CTRL_ADDR, smc_pkg::CTRL_RESET);
    sfr(1'b0, 8'hc3, 8'h00);
    // Every divider code, mode and line; slow rate on the upper codes
    for (int m = 0; m < 8; m++) begin
      ctl = {3'(m), 2'(m), 2'(m), 1'b1};
      // Line zero must still work with the enable off
      i_select_lines_enable <= (m != 4);
      sfr(1'b1, smc_pkg::CONFIG_ADDR, {4'h0, m >= 4, 3'h0});
      sfr(1'b1, smc_pkg::CTRL_ADDR, ctl);
      sfr(1'b0, smc_pkg::CTRL_ADDR, ctl);
      sfr(1'b0, smc_pkg::CONFIG_ADDR, {4'h0, m >= 4, 3'h0});
      reply = 8'($urandom);
      send(m == 1 ? 10 : 1);
    end
    sfr(1'b1, smc_pkg::CTRL_ADDR, 8'h10);
    repeat (20) @(posedge i_core_clk);
    i_select_lines_enable <= 1'b0;
    sfr(1'b1, smc_pkg::CTRL_ADDR, 8'h11);
    i_serial_port_enable <= 1'b0;
    sfr(1'b1, smc_pkg::CTRL_ADDR, 8'h01);
    sfr(1'b0, smc_pkg::CTRL_ADDR, 8'h00);
    i_serial_port_enable <= 1'b1;
    sfr(1'b0, smc_pkg::CTRL_ADDR, 8'h11);
    wrap_up();
  end
endmodule // spi_master_mode_control_tb_top
